// ---- hw/olsns_top.sv ----
// olsns_top: on-state open-load diagnosis and sense output control, two channels
// assumes: AXI4-Lite master on aclk; comparator and settle levels are async pins
// Function
// - flag open load below ratio-dependent current threshold
// - open load drives fault pin low, sets flag
// - fault pin recovers when cause gone; flag stays
// - high ratio checks continuously during on time
// - high ratio: read while off clears flag
// - high ratio: read while on clears if gone
// - low ratio checks at events, fast slew only
// - internal pwm checks at turnoff after interval
// - internal pwm check works at full duty
// - direct input checks each turnoff, none at full
// - low ratio clears on read after clean check
// - two select bits route channel or temperature
// - overcurrent window disables sensing, valid pin high
// - mode bit: 0 synchronous, 1 track-hold
// - synchronous sense only while channel conducts
// - track-hold keeps value from before turnoff
// - ratio bit picks ratio, lowers overcurrent thresholds
// - valid pin low once settled until switch-off
// - track-hold samples at switch-off, pin high
// - diagnostic disable bits suppress their checks
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "olsns_defines.svh"
module olsns_top import olsns_pkg::*; #(
   parameter int unsigned CHECK_CYCLES = 32'(64'(`OLSNS_INTERVAL_MS) *
      64'(`OLSNS_CLK_HZ) / 64'(`OLSNS_MS_PER_S))
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [`OLSNS_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [`OLSNS_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel state from the switch control, on aclk
   input wire logic [1:0] ch_on,
   input wire logic [1:0] duty_full,
   input wire logic [1:0] oc_window,
   // analogue levels, asynchronous
   input wire logic [1:0] ol_cmp_low,
   input wire logic [1:0] sense_settled,
   // pins and analogue controls
   output logic fault_status_pin_n,
   output logic sense_valid_pin_n,
   output logic [1:0] sense_select,
   output logic sense_enable,
   output logic sense_hold,
   output logic sense_ratio_low,
   output logic [1:0] offstate_check_en,
   output logic [1:0] battery_short_check_en
);
   logic [2:0] gcr_reg;
   logic ocr_reg;
   logic [8:0] cfg_reg [2];
   logic aw_full_reg;
   logic w_full_reg;
   logic aw_full_next;
   logic w_full_next;
   logic [`OLSNS_AW-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_go;
   logic rd_go;
   logic [31:0] rd_val;
   logic rd_ok;
   logic wr_ok;
   logic [1:0] cmp_s;
   logic [1:0] settled_s;
   logic [1:0] flag;
   logic [1:0] cause;
   logic sel_cur;
   logic sel_idx;
   olsns_sel_t sel;

   olsns_diag_if dif[2] ();

   function automatic logic [31:0] wmerge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // pin levels pass two flops first
   olsns_sync #(.W(2)) u_sync_cmp (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(ol_cmp_low),
      .q(cmp_s)
   );

   olsns_sync #(.W(2)) u_sync_set (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(sense_settled),
      .q(settled_s)
   );

   // per-channel open-load checkers
   for (genvar c = 0; c < 2; c++) begin : g_ch
      assign dif[c].low_ratio = ocr_reg;
      assign dif[c].on = ch_on[c];
      assign dif[c].duty_full = duty_full[c];
      assign dif[c].fast_slew = cfg_reg[c][`OLSNS_CFG_FAST];
      assign dif[c].int_pwm = cfg_reg[c][`OLSNS_CFG_DIRDIS];
      assign dif[c].diag_off = cfg_reg[c][`OLSNS_CFG_ONDIS];
      assign dif[c].cmp_low = cmp_s[c];
      assign flag[c] = dif[c].flag;
      assign cause[c] = dif[c].cause;
      olsns_onstate_openload_flag #(.CHECK_CYCLES(CHECK_CYCLES)) u_onstate_openload_flag (
         .aclk(aclk),
         .aresetn(aresetn),
         .d(dif[c])
      );
   end

   // read of a fault register is a clear request
   assign dif[0].read_fault = rd_go & (s_axi_araddr == `OLSNS_ADDR_FLT0);
   assign dif[1].read_fault = rd_go & (s_axi_araddr == `OLSNS_ADDR_FLT1);

   // write channel capture, address and data in either order
   assign wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign aw_full_next = (aw_full_reg & ~wr_go) | (s_axi_awvalid & s_axi_awready);
   assign w_full_next = (w_full_reg & ~wr_go) | (s_axi_wvalid & s_axi_wready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         s_axi_awready <= 1'b0;
      end else begin
         aw_full_reg <= aw_full_next;
         s_axi_awready <= ~aw_full_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_reg <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         w_full_reg <= w_full_next;
         s_axi_wready <= ~w_full_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
      end
   end

   always_comb begin
      unique case (awaddr_reg)
         `OLSNS_ADDR_GCR, `OLSNS_ADDR_OCR, `OLSNS_ADDR_CFG0, `OLSNS_ADDR_CFG1,
         `OLSNS_ADDR_FLT0, `OLSNS_ADDR_FLT1, `OLSNS_ADDR_STAT: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OLSNS_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? `OLSNS_RESP_OKAY : `OLSNS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gcr_reg <= `OLSNS_GCR_RST;
      end else if (wr_go && awaddr_reg == `OLSNS_ADDR_GCR) begin
         gcr_reg <= 3'(wmerge(32'(gcr_reg), wdata_reg, wstrb_reg));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ocr_reg <= `OLSNS_OCR_RST;
      end else if (wr_go && awaddr_reg == `OLSNS_ADDR_OCR) begin
         ocr_reg <= 1'(wmerge(32'(ocr_reg), wdata_reg, wstrb_reg) >> `OLSNS_OCR_RATIO);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_reg[0] <= `OLSNS_CFG_RST;
         cfg_reg[1] <= `OLSNS_CFG_RST;
      end else if (wr_go && awaddr_reg == `OLSNS_ADDR_CFG0) begin
         cfg_reg[0] <= 9'(wmerge(32'(cfg_reg[0]), wdata_reg, wstrb_reg));
      end else if (wr_go && awaddr_reg == `OLSNS_ADDR_CFG1) begin
         cfg_reg[1] <= 9'(wmerge(32'(cfg_reg[1]), wdata_reg, wstrb_reg));
      end
   end

   // read channel
   assign rd_go = s_axi_arvalid & s_axi_arready;

   always_comb begin
      rd_val = 32'h0;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `OLSNS_ADDR_GCR: rd_val = 32'(gcr_reg);
         `OLSNS_ADDR_OCR: rd_val = 32'(ocr_reg);
         `OLSNS_ADDR_CFG0: rd_val = 32'(cfg_reg[0]);
         `OLSNS_ADDR_CFG1: rd_val = 32'(cfg_reg[1]);
         `OLSNS_ADDR_FLT0: rd_val[`OLSNS_FLT_ONSTATE_OPENLOAD_FLAG] = flag[0];
         `OLSNS_ADDR_FLT1: rd_val[`OLSNS_FLT_ONSTATE_OPENLOAD_FLAG] = flag[1];
         `OLSNS_ADDR_STAT: begin
            rd_val[`OLSNS_STAT_CAUSE +: 2] = cause;
            rd_val[`OLSNS_STAT_ON +: 2] = ch_on;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= ~s_axi_rvalid | s_axi_rready;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `OLSNS_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? `OLSNS_RESP_OKAY : `OLSNS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // fault pin low while any open-load cause stands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_status_pin_n <= 1'b1;
      end else begin
         fault_status_pin_n <= ~|cause;
      end
   end

   // sense routing
   assign sel = olsns_sel_t'({gcr_reg[`OLSNS_GCR_SEL1], gcr_reg[`OLSNS_GCR_SEL0]});
   assign sel_cur = (sel == OLSNS_SEL_CH0) | (sel == OLSNS_SEL_CH1);
   assign sel_idx = (sel == OLSNS_SEL_CH1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_select <= OLSNS_SEL_NONE;
         sense_ratio_low <= 1'b0;
      end else begin
         sense_select <= sel;
         sense_ratio_low <= ocr_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_enable <= 1'b0;
      end else if (sel == OLSNS_SEL_TEMP) begin
         sense_enable <= 1'b1;
      end else if (!sel_cur || oc_window[sel_idx]) begin
         sense_enable <= 1'b0;
      end else if (gcr_reg[`OLSNS_GCR_TH]) begin
         sense_enable <= 1'b1;
      end else begin
         sense_enable <= ch_on[sel_idx];
      end
   end

   // hold level freezes the value taken at switch-off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_hold <= 1'b0;
      end else begin
         sense_hold <= gcr_reg[`OLSNS_GCR_TH] & sel_cur & ~ch_on[sel_idx];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sense_valid_pin_n <= 1'b1;
      end else if (!sel_cur || oc_window[sel_idx]) begin
         sense_valid_pin_n <= 1'b1;
      end else if (!ch_on[sel_idx]) begin
         sense_valid_pin_n <= 1'b1;
      end else if (settled_s[sel_idx]) begin
         sense_valid_pin_n <= 1'b0;
      end
   end

   // other diagnostics gated by their disable bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offstate_check_en <= 2'h0;
         battery_short_check_en <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            offstate_check_en[c] <= ~cfg_reg[c][`OLSNS_CFG_OFFDIS];
            battery_short_check_en[c] <= ~cfg_reg[c][`OLSNS_CFG_SHORTDIS];
         end
      end
   end
endmodule
`default_nettype wire

// ---- hw/olsns_defines.svh ----
// olsns_defines.svh: register offsets, field positions, reset values, timing
// assumes: included by bare name after the package is compiled
`ifndef OLSNS_DEFINES_SVH
`define OLSNS_DEFINES_SVH
`define OLSNS_AW 5
`define OLSNS_ADDR_GCR 5'h00
`define OLSNS_ADDR_OCR 5'h04
`define OLSNS_ADDR_CFG0 5'h08
`define OLSNS_ADDR_CFG1 5'h0c
`define OLSNS_ADDR_FLT0 5'h10
`define OLSNS_ADDR_FLT1 5'h14
`define OLSNS_ADDR_STAT 5'h18
`define OLSNS_GCR_SEL0 0
`define OLSNS_GCR_SEL1 1
`define OLSNS_GCR_TH 2
`define OLSNS_OCR_RATIO 0
`define OLSNS_CFG_FAST 4
`define OLSNS_CFG_DIRDIS 5
`define OLSNS_CFG_SHORTDIS 6
`define OLSNS_CFG_OFFDIS 7
`define OLSNS_CFG_ONDIS 8
`define OLSNS_FLT_ONSTATE_OPENLOAD_FLAG 0
`define OLSNS_STAT_CAUSE 0
`define OLSNS_STAT_ON 2
`define OLSNS_GCR_RST 3'h0
`define OLSNS_OCR_RST 1'h0
`define OLSNS_CFG_RST 9'h000
`define OLSNS_RESP_OKAY 2'h0
`define OLSNS_RESP_SLVERR 2'h2
`define OLSNS_INTERVAL_MS 150
`define OLSNS_CLK_HZ 20000000
`define OLSNS_MS_PER_S 1000
`endif

// ---- hw/olsns_pkg.sv ----
// olsns_pkg: types shared by the open-load and sense control block
// assumes: compiled before every other file of the block
package olsns_pkg;
   typedef enum logic [1:0] {
      OLSNS_SEL_NONE = 2'b00,
      OLSNS_SEL_CH0 = 2'b01,
      OLSNS_SEL_CH1 = 2'b10,
      OLSNS_SEL_TEMP = 2'b11
   } olsns_sel_t;
   typedef enum logic [1:0] {
      OLSNS_MODE_HI = 2'b00,
      OLSNS_MODE_LO_PWM = 2'b01,
      OLSNS_MODE_LO_DIR = 2'b10
   } olsns_mode_t;
endpackage

// ---- hw/olsns_diag_if.sv ----
// olsns_diag_if: signals between the top and one channel's open-load checker
// assumes: one instance per channel, all on aclk
`timescale 1ns/1ps
`default_nettype none
interface olsns_diag_if;
   logic low_ratio;
   logic on;
   logic duty_full;
   logic fast_slew;
   logic int_pwm;
   logic diag_off;
   logic cmp_low;
   logic read_fault;
   logic flag;
   logic cause;
   modport top (output low_ratio, on, duty_full, fast_slew, int_pwm, diag_off,
      cmp_low, read_fault, input flag, cause);
   modport onstate_openload_flag (input low_ratio, on, duty_full, fast_slew, int_pwm, diag_off,
      cmp_low, read_fault, output flag, cause);
endinterface
`default_nettype wire

// ---- hw/olsns_sync.sv ----
// olsns_sync: two-flop synchroniser for pin levels
// assumes: inputs are asynchronous levels, aclk is the only clock
`timescale 1ns/1ps
`default_nettype none
module olsns_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ---- hw/olsns_onstate_openload_flag.sv ----
// olsns_onstate_openload_flag: on-state open-load detection and flag for one channel
// assumes: all inputs on aclk; cmp_low already synchronised
`timescale 1ns/1ps
`default_nettype none
module olsns_onstate_openload_flag import olsns_pkg::*; #(
   parameter int unsigned CHECK_CYCLES = 3000000
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // channel link
   olsns_diag_if.onstate_openload_flag d
);
   localparam int unsigned CW = $clog2(CHECK_CYCLES + 1);
   logic [CW-1:0] cnt_reg;
   logic on_d_reg;
   logic flag_reg;
   logic cause_reg;
   logic clean_reg;
   logic turnoff;
   logic elapsed;
   logic chk_evt;
   logic live;
   logic flag_set;
   logic flag_clr;
   olsns_mode_t mode;

   assign turnoff = on_d_reg & ~d.on;
   assign elapsed = (cnt_reg == CW'(CHECK_CYCLES - 1));
   assign live = d.on & d.cmp_low;
   assign d.flag = flag_reg;
   assign d.cause = cause_reg;

   always_comb begin
      if (!d.low_ratio) begin
         mode = OLSNS_MODE_HI;
      end else if (d.int_pwm) begin
         mode = OLSNS_MODE_LO_PWM;
      end else begin
         mode = OLSNS_MODE_LO_DIR;
      end
   end

   always_comb begin
      chk_evt = 1'b0;
      flag_set = 1'b0;
      flag_clr = 1'b0;
      unique case (mode)
         OLSNS_MODE_HI: begin
            flag_set = ~d.diag_off & live;
            flag_clr = d.read_fault & (~d.on | ~d.cmp_low);
         end
         OLSNS_MODE_LO_PWM: begin
            chk_evt = d.fast_slew & elapsed & (turnoff | (d.on & d.duty_full));
            flag_set = ~d.diag_off & chk_evt & d.cmp_low;
            flag_clr = d.read_fault & clean_reg;
         end
         OLSNS_MODE_LO_DIR: begin
            chk_evt = d.fast_slew & turnoff;
            flag_set = ~d.diag_off & chk_evt & d.cmp_low;
            flag_clr = d.read_fault & clean_reg;
         end
         default: begin
            chk_evt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_d_reg <= 1'b0;
      end else begin
         on_d_reg <= d.on;
      end
   end

   // interval restarts at each detection event
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
      end else if (chk_evt) begin
         cnt_reg <= '0;
      end else if (!elapsed) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   // set wins over a read clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 1'b0;
      end else if (flag_set) begin
         flag_reg <= 1'b1;
      end else if (flag_clr) begin
         flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clean_reg <= 1'b0;
      end else if (chk_evt) begin
         clean_reg <= ~d.cmp_low;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cause_reg <= 1'b0;
      end else if (d.diag_off) begin
         cause_reg <= 1'b0;
      end else if (mode == OLSNS_MODE_HI) begin
         cause_reg <= live;
      end else if (chk_evt) begin
         cause_reg <= d.cmp_low;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/olsns_assertions.sv ----
// olsns_assertions: port-level checks of bus handshakes, sense pin and fault pin
// assumes: bound into olsns_top, single clock aclk, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module olsns_assertions import olsns_pkg::*; (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel state and pins
   input wire logic [1:0] ch_on,
   input wire logic [1:0] oc_window,
   input wire logic [1:0] ol_cmp_low,
   input wire logic fault_status_pin_n,
   input wire logic sense_valid_pin_n,
   input wire logic [1:0] sense_select,
   input wire logic sense_ratio_low
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
   wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read data not held");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   oc_valid_a: assert property ((sense_select == OLSNS_SEL_CH0 && oc_window[0]) [*2] |->
      sense_valid_pin_n) else $error("sense valid in overcurrent window");
   temp_valid_a: assert property ((sense_select == OLSNS_SEL_TEMP) [*2] |->
      sense_valid_pin_n) else $error("sense valid on temperature");
   off_valid_a: assert property ((sense_select == OLSNS_SEL_CH0 && !ch_on[0]) [*2] |->
      sense_valid_pin_n) else $error("sense valid with channel off");
   ol_pin_a: assert property ((!sense_ratio_low && ch_on[0] && ol_cmp_low[0]) [*5] |->
      !fault_status_pin_n) else $error("fault pin high on open load");
   ol_clear_a: assert property ((!sense_ratio_low && ol_cmp_low == 2'h0) [*5] |->
      fault_status_pin_n) else $error("fault pin low without cause");
   cover property (!fault_status_pin_n);
   cover property (sense_select == OLSNS_SEL_CH0 && !sense_valid_pin_n);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind olsns_top olsns_assertions chk_u (.*);
`default_nettype wire

// ---- testbench/olsns_mcu_model.sv ----
// olsns_mcu_model: controller side, one register access at a time over the bus
// assumes: tasks called from the bench; waits end only by the bench watchdog
`timescale 1ns/1ps
`default_nettype none
`include "olsns_defines.svh"
module olsns_mcu_model (
   // clock
   input wire logic aclk,
   // write channels
   output logic [`OLSNS_AW-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read channels
   output logic [`OLSNS_AW-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      s_axi_awaddr = '0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = '0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
   end
   task automatic wr(input logic [`OLSNS_AW-1:0] a, input logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [`OLSNS_AW-1:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- testbench/olsns_tb_top.sv ----
// olsns_tb_top: scenarios for open-load flagging and sense output control
// assumes: interval shortened to 20 cycles; controller model drives the bus
`timescale 1ns/1ps
`default_nettype none
`include "olsns_defines.svh"
module olsns_tb_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [1:0] ch_on = 2'h0, duty_full = 2'h0, oc_window = 2'h0;
   logic [1:0] ol_cmp_low = 2'h0, sense_settled = 2'h0;
   logic [`OLSNS_AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, sense_select;
   logic [1:0] offstate_check_en, battery_short_check_en;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic fault_status_pin_n, sense_valid_pin_n, sense_enable, sense_hold, sense_ratio_low;
   int fails = 0;
   int n_tests = 0;
   always #25 aclk = ~aclk;
   olsns_top #(.CHECK_CYCLES(20)) dut_u (.*);
   olsns_mcu_model mcu_u (.*);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      if (fails == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic rdchk(input string what, input logic [4:0] a, input logic [31:0] exp);
      mcu_u.rd(a, rd_v, rsp);
      chk(what, rd_v, exp);
   endtask
   task automatic t_reset;
      rdchk("gcr", `OLSNS_ADDR_GCR, 32'h0);
      rdchk("ocr", `OLSNS_ADDR_OCR, 32'h0);
      rdchk("cfg1", `OLSNS_ADDR_CFG1, 32'h0);
      chk("offstate_en", 32'(offstate_check_en), 32'h3);
      mcu_u.rd(5'h1c, rd_v, rsp);
      chk("unmapped rresp", 32'(rsp), 32'(`OLSNS_RESP_SLVERR));
      chk("unmapped rdata", rd_v, 32'h0);
      mcu_u.wr(5'h1c, 32'hffff_ffff, rsp);
      chk("unmapped bresp", 32'(rsp), 32'(`OLSNS_RESP_SLVERR));
   endtask
   task automatic t_sense;
      for (int i = 0; i < 4; i++) begin
         mcu_u.wr(`OLSNS_ADDR_GCR, 32'(i), rsp);
         cyc(2);
         chk("sense_select", 32'(sense_select), 32'(i));
      end
      chk("temp enable", 32'(sense_enable), 32'h1);
      mcu_u.wr(`OLSNS_ADDR_GCR, 32'h1, rsp);
      ch_on[0] <= 1'b1;
      sense_settled[0] <= 1'b1;
      cyc(6);
      chk("valid after settle", 32'(sense_valid_pin_n), 32'h0);
      oc_window[0] <= 1'b1;
      cyc(3);
      chk("valid in oc window", 32'(sense_valid_pin_n), 32'h1);
      oc_window[0] <= 1'b0;
      cyc(6);
      chk("sync hold", 32'(sense_hold), 32'h0);
      ch_on[0] <= 1'b0;
      cyc(3);
      chk("valid after off", 32'(sense_valid_pin_n), 32'h1);
      mcu_u.wr(`OLSNS_ADDR_GCR, 32'h5, rsp);
      ch_on[0] <= 1'b1;
      cyc(6);
      ch_on[0] <= 1'b0;
      cyc(3);
      chk("track hold", 32'(sense_hold), 32'h1);
      chk("valid on hold", 32'(sense_valid_pin_n), 32'h1);
   endtask
   task automatic t_hi;
      ch_on[0] <= 1'b1;
      ol_cmp_low[0] <= 1'b1;
      cyc(6);
      chk("fault pin", 32'(fault_status_pin_n), 32'h0);
      ol_cmp_low[0] <= 1'b0;
      cyc(6);
      chk("fault pin back", 32'(fault_status_pin_n), 32'h1);
      rdchk("flag latched", `OLSNS_ADDR_FLT0, 32'h1);
      rdchk("flag cleared on", `OLSNS_ADDR_FLT0, 32'h0);
      ol_cmp_low[0] <= 1'b1;
      cyc(6);
      rdchk("flag set", `OLSNS_ADDR_FLT0, 32'h1);
      rdchk("flag kept on", `OLSNS_ADDR_FLT0, 32'h1);
      ch_on[0] <= 1'b0;
      cyc(2);
      rdchk("flag read off", `OLSNS_ADDR_FLT0, 32'h1);
      rdchk("flag cleared off", `OLSNS_ADDR_FLT0, 32'h0);
      ol_cmp_low[0] <= 1'b0;
   endtask
   task automatic t_lo;
      mcu_u.wr(`OLSNS_ADDR_OCR, 32'h1, rsp);
      mcu_u.wr(`OLSNS_ADDR_CFG0, 32'h10, rsp);
      chk("ratio low", 32'(sense_ratio_low), 32'h1);
      ch_on[0] <= 1'b1;
      ol_cmp_low[0] <= 1'b1;
      cyc(8);
      rdchk("no check while on", `OLSNS_ADDR_FLT0, 32'h0);
      ch_on[0] <= 1'b0;
      cyc(4);
      rdchk("turnoff check", `OLSNS_ADDR_FLT0, 32'h1);
      rdchk("kept after faulty", `OLSNS_ADDR_FLT0, 32'h1);
      ol_cmp_low[0] <= 1'b0;
      ch_on[0] <= 1'b1;
      cyc(6);
      ch_on[0] <= 1'b0;
      cyc(4);
      rdchk("read after clean", `OLSNS_ADDR_FLT0, 32'h1);
      rdchk("cleared after clean", `OLSNS_ADDR_FLT0, 32'h0);
      mcu_u.wr(`OLSNS_ADDR_CFG0, 32'h0, rsp);
      ol_cmp_low[0] <= 1'b1;
      ch_on[0] <= 1'b1;
      cyc(6);
      ch_on[0] <= 1'b0;
      cyc(4);
      rdchk("slow slew no check", `OLSNS_ADDR_FLT0, 32'h0);
      ol_cmp_low[0] <= 1'b0;
   endtask
   task automatic t_pwm;
      mcu_u.wr(`OLSNS_ADDR_CFG0, 32'h30, rsp);
      duty_full[0] <= 1'b1;
      ch_on[0] <= 1'b1;
      ol_cmp_low[0] <= 1'b1;
      cyc(60);
      rdchk("full duty check", `OLSNS_ADDR_FLT0, 32'h1);
      ol_cmp_low[0] <= 1'b0;
      cyc(60);
      rdchk("periodic clean", `OLSNS_ADDR_FLT0, 32'h1);
      rdchk("periodic cleared", `OLSNS_ADDR_FLT0, 32'h0);
      duty_full[0] <= 1'b0;
      ol_cmp_low[0] <= 1'b1;
      cyc(60);
      rdchk("no turnoff no check", `OLSNS_ADDR_FLT0, 32'h0);
      ch_on[0] <= 1'b0;
      cyc(4);
      rdchk("turnoff after interval", `OLSNS_ADDR_FLT0, 32'h1);
      ol_cmp_low[0] <= 1'b0;
   endtask
   task automatic t_dis;
      mcu_u.wr(`OLSNS_ADDR_OCR, 32'h0, rsp);
      mcu_u.wr(`OLSNS_ADDR_CFG1, 32'h1c0, rsp);
      cyc(2);
      chk("offstate_en", 32'(offstate_check_en), 32'h1);
      chk("short_en", 32'(battery_short_check_en), 32'h1);
      ch_on[1] <= 1'b1;
      ol_cmp_low[1] <= 1'b1;
      cyc(6);
      chk("pin suppressed", 32'(fault_status_pin_n), 32'h1);
      rdchk("flag suppressed", `OLSNS_ADDR_FLT1, 32'h0);
      ch_on[1] <= 1'b0;
      ol_cmp_low[1] <= 1'b0;
   endtask
   initial begin
      cyc(2);
      aresetn <= 1'b1;
      cyc(2);
      t_reset();
      t_sense();
      t_hi();
      t_lo();
      t_pwm();
      t_dis();
      close_out();
   end
   initial begin
      cyc(20000);
      fails++;
      close_out();
   end
endmodule
`default_nettype wire
